// [rtl/wavext_pkg.sv]
package wavext_pkg;
  // register byte addresses (registers at their printed order, one word each)
  localparam logic [5:0] ctrl_addr          = 6'h00;
  localparam logic [5:0] fault_mask_addr    = 6'h04;
  localparam logic [5:0] fault_ctrl_addr    = 6'h08;
  localparam logic [5:0] status_addr        = 6'h0C;
  localparam logic [5:0] dt_both_addr       = 6'h10;
  localparam logic [5:0] dt_both_buf_addr   = 6'h14;
  localparam logic [5:0] low_dt_addr        = 6'h18;
  localparam logic [5:0] high_dt_addr       = 6'h1C;
  localparam logic [5:0] low_dt_buf_addr    = 6'h20;
  localparam logic [5:0] high_dt_buf_addr   = 6'h24;
  localparam logic [5:0] override_addr      = 6'h28;
  localparam logic [5:0] lock_addr          = 6'h2C;
  localparam logic [5:0] dir_addr           = 6'h30;
  // control register fields
  localparam int ctrl_pattern_bit  = 5;
  localparam int ctrl_common_bit   = 4;
  // fault control fields
  localparam int fctl_dbg_bit      = 4;
  localparam int fctl_mode_bit     = 2;
  localparam logic [1:0] fault_act_none     = 2'h0;
  localparam logic [1:0] fault_act_cleardir = 2'h3;
  // status fields
  localparam int stat_fault_bit    = 2;
  localparam int stat_hbufv_bit    = 1;
  localparam int stat_lbufv_bit    = 0;
  // reset values
  localparam logic [7:0] reg8_reset = 8'h00;
  localparam int num_channels = 4;
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0] {
    wavext_run   = 2'b01,
    wavext_fault = 2'b10
  } wavext_fault_e;
endpackage

// [rtl/wavext_top.sv]
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
// What this block does
// - outside pattern mode, each generator turns its timer waveform, or channel A's in common mode, into a complementary pair
// - low side is the waveform, high side its inverse, dead time between
// - both sides held low during dead time
// - four identical generators share one double-buffered low/high dead-time setting
// - 8-bit counter decrements each clock and stops at zero
// - nonzero counter forces both sides off
// - rising edge reloads low-side value, falling edge reloads high-side value
// - pattern mode bypasses dead time and reuses its storage as a pattern
// - in pattern mode, override-enabled pins carry the channel A waveform
// - buffered values copy to active registers only on timer update
// - dead-time enabled channel's pins follow override bits, not compare enables
// - any masked event channel is a fault; selected channels are ORed
// - direction-clear action clears port direction bits on fault
// - fault sets detect flag and timer error flag, raises enabled error interrupt
// - fault action takes effect within two clock cycles
// - latched restore waits for inactive input and cleared flag, then update
// - cycle-by-cycle restore waits for inactive input, then update
// - leaving fault restores direction bits of enabled dead-time channels
// - fault keeps override register but blocks software writes to it
// - lock bit blocks writes to control, override and fault mask registers
// - fault action code 00 means none, 11 means clear directions
// - restore mode bit clear is latched, set is cycle-by-cycle
// - dead-time values count peripheral clock cycles
// - debugger break is a fault unless the debug-break disable bit is set
module wavext_top (
  input  wire logic        aclk,            // peripheral clock, 100 MHz
  input  wire logic        aresetn,         // synchronous reset, active low
  input  wire logic [5:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // write strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [5:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  input  wire logic [3:0]  wave_in,         // timer waveform per compare channel
  input  wire logic [3:0]  compare_output_enable, // timer per-channel output enables
  input  wire logic        update_pulse,    // timer update condition, one cycle
  input  wire logic        lock_update,     // timer lock-update flag
  input  wire logic [7:0]  event_in,        // event channels
  input  wire logic        debug_break,     // debugger break request
  output logic [7:0]       pin_out,         // port output value
  output logic [7:0]       pin_override,    // per-pin override of port output
  output logic [7:0]       pin_dir,         // port direction, 1 = output
  output logic             timer_error_flag,// error flag set into timer, high each cycle after fault input is active
  output logic             error_irq        // error interrupt request, level
);

  localparam int nch = wavext_pkg::num_channels;

  // software registers
  logic [7:0] ctrl;
  logic [7:0] fault_mask;
  logic [7:0] fault_ctrl;
  logic [7:0] low_dt;
  logic [7:0] high_dt;
  logic [7:0] low_dt_buf;
  logic [7:0] high_dt_buf;
  logic       low_bufv;
  logic       high_bufv;
  logic [7:0] override_enable_bits;
  logic       lock;
  logic       error_irq_en;
  logic [7:0] dir_soft;
  logic       fault_flag;
  wavext_pkg::wavext_fault_e fstate;

  // axi write path: address and data captured independently
  logic       aw_held;
  logic       w_held;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire do_write = aw_held && w_held && !s_axi_bvalid;
  wire wr_lane0 = do_write && w_strb[0];
  wire [7:0] wbyte = w_data[7:0];

  function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
    return a == r;
  endfunction

  wire known_w = hit(aw_addr, wavext_pkg::ctrl_addr) || hit(aw_addr, wavext_pkg::fault_mask_addr)
    || hit(aw_addr, wavext_pkg::fault_ctrl_addr) || hit(aw_addr, wavext_pkg::status_addr)
    || hit(aw_addr, wavext_pkg::dt_both_addr) || hit(aw_addr, wavext_pkg::dt_both_buf_addr)
    || hit(aw_addr, wavext_pkg::low_dt_addr) || hit(aw_addr, wavext_pkg::high_dt_addr)
    || hit(aw_addr, wavext_pkg::low_dt_buf_addr) || hit(aw_addr, wavext_pkg::high_dt_buf_addr)
    || hit(aw_addr, wavext_pkg::override_addr) || hit(aw_addr, wavext_pkg::lock_addr)
    || hit(aw_addr, wavext_pkg::dir_addr);

  wire in_fault = (fstate == wavext_pkg::wavext_fault);
  wire wr_ctrl  = wr_lane0 && hit(aw_addr, wavext_pkg::ctrl_addr) && !lock;
  wire wr_mask  = wr_lane0 && hit(aw_addr, wavext_pkg::fault_mask_addr) && !lock;
  wire wr_fctl  = wr_lane0 && hit(aw_addr, wavext_pkg::fault_ctrl_addr);
  wire wr_stat  = wr_lane0 && hit(aw_addr, wavext_pkg::status_addr);
  wire wr_both  = wr_lane0 && hit(aw_addr, wavext_pkg::dt_both_addr);
  wire wr_bothb = wr_lane0 && hit(aw_addr, wavext_pkg::dt_both_buf_addr);
  wire wr_low   = wr_both || (wr_lane0 && hit(aw_addr, wavext_pkg::low_dt_addr));
  wire wr_high  = wr_both || (wr_lane0 && hit(aw_addr, wavext_pkg::high_dt_addr));
  wire wr_lowb  = wr_bothb || (wr_lane0 && hit(aw_addr, wavext_pkg::low_dt_buf_addr));
  wire wr_highb = wr_bothb || (wr_lane0 && hit(aw_addr, wavext_pkg::high_dt_buf_addr));
  wire wr_ovr   = wr_lane0 && hit(aw_addr, wavext_pkg::override_addr) && !lock && !fault_flag
                  && !in_fault;
  wire wr_lock  = wr_lane0 && hit(aw_addr, wavext_pkg::lock_addr);
  wire wr_dir   = wr_lane0 && hit(aw_addr, wavext_pkg::dir_addr);

  // fault detection
  wire [1:0] fault_act   = fault_ctrl[1:0];
  wire       prot_on     = (fault_act == wavext_pkg::fault_act_cleardir);
  wire       dbg_fault   = debug_break && !fault_ctrl[wavext_pkg::fctl_dbg_bit];
  wire       fault_input = prot_on && ((|(event_in & fault_mask)) || dbg_fault);
  wire       cyc_mode    = fault_ctrl[wavext_pkg::fctl_mode_bit];
  wire       flag_clr    = wr_stat && wbyte[wavext_pkg::stat_fault_bit];
  // set wins over a clear in the same cycle
  wire       next_fault_flag = fault_input || (fault_flag && !flag_clr);
  wire       may_leave   = !fault_input && (cyc_mode || !fault_flag);

  wavext_pkg::wavext_fault_e next_fstate;
  always_comb begin
    next_fstate = fstate;
    case (fstate)
      wavext_pkg::wavext_run:
        if (fault_input) next_fstate = wavext_pkg::wavext_fault;
      wavext_pkg::wavext_fault:
        if (may_leave && update_pulse) next_fstate = wavext_pkg::wavext_run;
      default: next_fstate = wavext_pkg::wavext_run;
    endcase
  end

  // buffered update, held off by the timer lock-update flag
  wire upd = update_pulse && !lock_update;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                 <= wavext_pkg::reg8_reset;
      fault_mask           <= wavext_pkg::reg8_reset;
      fault_ctrl           <= wavext_pkg::reg8_reset;
      low_dt               <= wavext_pkg::reg8_reset;
      high_dt              <= wavext_pkg::reg8_reset;
      low_dt_buf           <= wavext_pkg::reg8_reset;
      high_dt_buf          <= wavext_pkg::reg8_reset;
      low_bufv             <= 1'b0;
      high_bufv            <= 1'b0;
      override_enable_bits <= wavext_pkg::reg8_reset;
      lock                 <= 1'b0;
      error_irq_en         <= 1'b0;
      dir_soft             <= wavext_pkg::reg8_reset;
      fault_flag           <= 1'b0;
      fstate               <= wavext_pkg::wavext_run;
    end else begin
      fstate     <= next_fstate;
      fault_flag <= next_fault_flag;
      if (wr_ctrl) ctrl <= {2'h0, wbyte[5:0]};
      if (wr_mask) fault_mask <= wbyte;
      if (wr_fctl) fault_ctrl <= {3'h0, wbyte[4], 1'b0, wbyte[2:0]};
      if (wr_ovr) override_enable_bits <= wbyte;
      // lock only sets; cleared by reset alone
      if (wr_lock && wbyte[0]) lock <= 1'b1;
      if (wr_lock) error_irq_en <= wbyte[1];
      if (wr_dir) dir_soft <= wbyte;
      // active values load from buffers on update
      if (wr_low) low_dt <= wbyte;
      else if (upd && low_bufv) low_dt <= low_dt_buf;
      if (wr_high) high_dt <= wbyte;
      else if (upd && high_bufv) high_dt <= high_dt_buf;
      if (wr_lowb) low_dt_buf <= wbyte;
      if (wr_highb) high_dt_buf <= wbyte;
      low_bufv  <= wr_lowb || (low_bufv && !upd);
      high_bufv <= wr_highb || (high_bufv && !upd);
    end
  end

  // dead-time generators
  wire        pattern_mode = ctrl[wavext_pkg::ctrl_pattern_bit];
  wire        common_mode  = ctrl[wavext_pkg::ctrl_common_bit];
  wire [3:0]  dt_enable    = ctrl[3:0];
  wire        ext_on       = pattern_mode || common_mode || (|dt_enable);
  logic [3:0] wave_q;
  wire  [3:0] low_side;
  wire  [3:0] high_side;

  genvar g;
  generate
    for (g = 0; g < nch; g++) begin : gen_dt
      logic [7:0] dt_count;
      wire src   = common_mode ? wave_in[0] : wave_in[g];
      wire rise  = src && !wave_q[g];
      wire fall  = !src && wave_q[g];
      // counter value after this cycle; outputs settle from it
      wire [7:0] next_count = rise ? low_dt : (fall ? high_dt :
                              ((dt_count != 8'h00) ? dt_count - 8'h01 : 8'h00));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          dt_count     <= 8'h00;
          wave_q[g]    <= 1'b0;
        end else begin
          wave_q[g]    <= src;
          dt_count     <= next_count;
        end
      end
      // no side register of its own: the pin flop is the single stage
      assign low_side[g]  = (next_count == 8'h00) && src;
      assign high_side[g] = (next_count == 8'h00) && !src;
    end
  endgenerate

  // pin assembly: channel n uses pins 2n (low) and 2n+1 (high)
  logic [7:0] dt_pins;
  logic [7:0] dt_owned;
  always_comb begin
    for (int i = 0; i < nch; i++) begin
      dt_pins[2*i]    = low_side[i];
      dt_pins[2*i+1]  = high_side[i];
      dt_owned[2*i]   = dt_enable[i];
      dt_owned[2*i+1] = dt_enable[i];
    end
  end

  logic [7:0] cmp_pins;
  always_comb begin
    for (int i = 0; i < nch; i++) begin
      cmp_pins[2*i]   = compare_output_enable[i];
      cmp_pins[2*i+1] = 1'b0;
    end
  end

  // pattern mode: active low dead-time register holds the pattern, override pins carry channel a
  wire [7:0] pat_value = low_dt;
  wire [7:0] pat_out   = (override_enable_bits & {8{wave_in[0]}})
                         | (~override_enable_bits & pat_value);
  // override bits rule owned pins, compare enables the rest
  wire [7:0] next_override = !ext_on ? cmp_pins
                           : pattern_mode ? override_enable_bits
                           : ((dt_owned & override_enable_bits) | (~dt_owned & cmp_pins));
  wire [7:0] next_out = pattern_mode ? pat_out : dt_pins;
  // enabled channel pins go to input while faulted, restored on exit
  wire       clear_dir = prot_on && (in_fault || fault_input);
  wire [7:0] dir_mask  = pattern_mode ? 8'hFF : dt_owned;
  wire [7:0] next_dir  = clear_dir ? (dir_soft & ~dir_mask) : dir_soft;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out          <= 8'h00;
      pin_override     <= 8'h00;
      pin_dir          <= 8'h00;
      timer_error_flag <= 1'b0;
      error_irq        <= 1'b0;
    end else begin
      pin_out          <= next_out;
      pin_override     <= next_override;
      pin_dir          <= next_dir;
      timer_error_flag <= fault_input;
      error_irq        <= next_fault_flag && error_irq_en;
    end
  end

  // axi handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 6'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= wavext_pkg::resp_okay;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_w ? wavext_pkg::resp_okay : wavext_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire [7:0] status = {5'h00, fault_flag, high_bufv, low_bufv};
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      wavext_pkg::ctrl_addr:        rd_byte = ctrl;
      wavext_pkg::fault_mask_addr:  rd_byte = fault_mask;
      wavext_pkg::fault_ctrl_addr:  rd_byte = fault_ctrl;
      wavext_pkg::status_addr:      rd_byte = status;
      wavext_pkg::low_dt_addr:      rd_byte = low_dt;
      wavext_pkg::high_dt_addr:     rd_byte = high_dt;
      wavext_pkg::low_dt_buf_addr:  rd_byte = low_dt_buf;
      wavext_pkg::high_dt_buf_addr: rd_byte = high_dt_buf;
      wavext_pkg::override_addr:    rd_byte = override_enable_bits;
      wavext_pkg::lock_addr:        rd_byte = {6'h00, error_irq_en, lock};
      wavext_pkg::dir_addr:         rd_byte = dir_soft;
      wavext_pkg::dt_both_addr:     rd_byte = 8'h00;
      wavext_pkg::dt_both_buf_addr: rd_byte = 8'h00;
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= wavext_pkg::resp_okay;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= rd_ok ? wavext_pkg::resp_okay : wavext_pkg::resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// [test/test_wavext_top.sv]
`timescale 1ns/100ps
module test_wavext_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, upd, lupd, dbg, terr, irq;
  logic [5:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, wave, coe;
  logic [7:0]  ev, pin_out, pin_ovr, pin_dir, gate, rv, mask;
  logic [1:0]  bresp, rresp, resp;
  int          n_errors, tests_run, seed, k, dl, dh;
  wavext_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wave_in(wave), .compare_output_enable(coe), .update_pulse(upd),
    .lock_update(lupd), .event_in(ev), .debug_break(dbg), .pin_out(pin_out),
    .pin_override(pin_ovr), .pin_dir(pin_dir), .timer_error_flag(terr), .error_irq(irq));
  wavext_stage u_stage (.pin_out(pin_out), .pin_override(pin_ovr), .port_value(8'h00),
    .pin_dir(pin_dir), .gate(gate));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bready and rready stay high, so every answer is taken at once
  // no cycle count assumed: only the watchdog ends a wait
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    awaddr  <= a;
    wdata   <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
  endtask
  task automatic rd(input logic [5:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv   = rdata[7:0];
    resp = rresp;
  endtask
  task automatic pulse();
    upd <= 1'b1;
    tick(1);
    upd <= 1'b0;
    tick(2);
  endtask
  function automatic logic [7:0] pair_exp(input logic v);
    return {6'h00, ~v, v};
  endfunction
  // counts cycles with both sides off after a waveform edge
  task automatic edge_count(input int ch, input logic v, input int exp_n);
    int n;
    n = 0;
    wave[ch] <= v;
    coe      <= 4'($random(seed));
    tick(2);
    while (pin_out[2*ch +: 2] === 2'b00 && n < 300) begin
      n++;
      tick(1);
    end
    check(n[7:0], exp_n[7:0]);
    check({6'h00, pin_out[2*ch +: 2]}, pair_exp(v));
  endtask
  initial begin
    #400000;
    n_errors++;
    complete_run();
  end
  initial begin
    {awvalid, wvalid, arvalid, upd, lupd, dbg} = 6'h00;
    {awaddr, araddr, wave, coe, ev, wdata} = 0;
    {bready, rready, wstrb} = 6'h3F;
    {n_errors, tests_run} = 0;
    seed = 80907;
    aresetn = 1'b0;
    tick(3);
    aresetn <= 1'b1;
    tick(1);
    rd(wavext_pkg::ctrl_addr);
    check(rv, wavext_pkg::reg8_reset);
    rd(6'h3C);
    check(rv, 8'h00);
    check({6'h00, resp}, {6'h00, wavext_pkg::resp_slverr});
    wr(6'h3C, 8'h11);
    check({6'h00, resp}, {6'h00, wavext_pkg::resp_slverr});
    wr(wavext_pkg::dir_addr, 8'hFF);
    wr(wavext_pkg::ctrl_addr, 8'h0F);
    for (int i = 0; i < 12; i++) begin
      k  = i % 4;
      dl = (i == 0) ? 0 : (i == 1) ? 255 : ($random(seed) & 8'h0F);
      dh = (i == 1) ? 1 : ($random(seed) & 8'h0F);
      wr(wavext_pkg::low_dt_addr, 8'(dl));
      wr(wavext_pkg::high_dt_addr, 8'(dh));
      edge_count(k, 1'b1, dl);
      edge_count(k, 1'b0, dh);
    end
    wr(wavext_pkg::low_dt_buf_addr, 8'h5A);
    rd(wavext_pkg::status_addr);
    check(rv, 8'h01);
    lupd <= 1'b1;
    pulse();
    rd(wavext_pkg::low_dt_addr);
    check(rv, 8'(dl));
    lupd <= 1'b0;
    pulse();
    rd(wavext_pkg::low_dt_addr);
    check(rv, 8'h5A);
    wr(wavext_pkg::dt_both_addr, 8'h33);
    rd(wavext_pkg::high_dt_addr);
    check(rv, 8'h33);
    // common mode: channel a feeds all four generators, dead time 0x33
    wr(wavext_pkg::ctrl_addr, 8'h1F);
    for (int i = 0; i < 2; i++) begin
      wave[0] <= ~i[0];
      tick(60);
      check(pin_out, i ? 8'hAA : 8'h55);
    end
    wr(wavext_pkg::override_addr, 8'hF0);
    wr(wavext_pkg::ctrl_addr, 8'h20);
    for (int i = 0; i < 2; i++) begin
      wave[0] <= ~i[0];
      tick(2);
      check(pin_out & 8'hF0, i ? 8'h00 : 8'hF0);
      check(pin_out & 8'h0F, 8'h03);
      check(pin_ovr, 8'hF0);
    end
    k    = $random(seed) & 7;
    mask = 8'h80 | (8'h01 << k);
    wr(wavext_pkg::ctrl_addr, 8'h0F);
    wr(wavext_pkg::override_addr, 8'hFF);
    tick(1);
    check(pin_ovr, 8'hFF);
    wr(wavext_pkg::fault_mask_addr, mask);
    wr(wavext_pkg::fault_ctrl_addr, 8'h07);
    wr(wavext_pkg::lock_addr, 8'h02);
    ev[k] <= 1'b1;
    tick(3);
    check(pin_dir, 8'h00);
    check(gate, 8'h00);
    check({7'h00, irq}, 8'h01);
    wr(wavext_pkg::override_addr, 8'h0F);
    rd(wavext_pkg::override_addr);
    check(rv, 8'hFF);
    ev[k] <= 1'b0;
    tick(3);
    check(pin_dir, 8'h00);
    pulse();
    check(pin_dir, 8'hFF);
    rd(wavext_pkg::status_addr);
    check(rv & 8'h04, 8'h04);
    wr(wavext_pkg::status_addr, 8'h04);
    wr(wavext_pkg::fault_ctrl_addr, 8'h03);
    ev[7] <= 1'b1;
    tick(1);
    ev[7] <= 1'b0;
    tick(3);
    check(pin_dir, 8'h00);
    pulse();
    check(pin_dir, 8'h00);
    wr(wavext_pkg::status_addr, 8'h04);
    pulse();
    check(pin_dir, 8'hFF);
    wr(wavext_pkg::fault_ctrl_addr, 8'h13);
    dbg <= 1'b1;
    tick(3);
    check(pin_dir, 8'hFF);
    wr(wavext_pkg::fault_ctrl_addr, 8'h03);
    tick(2);
    check(pin_dir, 8'h00);
    dbg <= 1'b0;
    tick(2);
    wr(wavext_pkg::status_addr, 8'h04);
    pulse();
    wr(wavext_pkg::fault_ctrl_addr, 8'h00);
    ev[k] <= 1'b1;
    tick(3);
    check(pin_dir, 8'hFF);
    ev[k] <= 1'b0;
    wr(wavext_pkg::lock_addr, 8'h01);
    wr(wavext_pkg::ctrl_addr, 8'h00);
    wr(wavext_pkg::fault_mask_addr, 8'h00);
    rd(wavext_pkg::ctrl_addr);
    check(rv, 8'h0F);
    rd(wavext_pkg::fault_mask_addr);
    check(rv, mask);
    complete_run();
  end
endmodule

// [test/wavext_props.sv]
`timescale 1ns/100ps
module wavext_props (
  input wire logic        aclk,             // clock
  input wire logic        aresetn,          // reset, active low
  input wire logic        s_axi_awready,    // write address ready
  input wire logic        s_axi_bvalid,     // write response valid
  input wire logic        s_axi_bready,     // write response ready
  input wire logic [1:0]  s_axi_bresp,      // write response
  input wire logic        s_axi_arready,    // read address ready
  input wire logic        s_axi_rvalid,     // read data valid
  input wire logic        s_axi_rready,     // read data ready
  input wire logic [31:0] s_axi_rdata,      // read data
  input wire logic [1:0]  s_axi_rresp,      // read response
  input wire logic [7:0]  event_in,         // event channels
  input wire logic        debug_break,      // break request
  input wire logic        update_pulse,     // timer update
  input wire logic [7:0]  pin_dir,          // port direction
  input wire logic        timer_error_flag  // fault seen
);
  logic       src_q;
  logic       upd_q;
  logic       upd_q2;
  logic       bv_q;
  logic [7:0] dir_q;
  always_ff @(posedge aclk) begin
    src_q <= (|event_in) | debug_break;
    upd_q <= update_pulse;
    upd_q2 <= upd_q;
    bv_q  <= s_axi_bvalid;
    dir_q <= pin_dir;
  end
  // a direction bit may only come back after an update or a register write
  // exit lands on the update edge, the pins follow one edge later
  wire logic dir_rise = |(pin_dir & ~dir_q);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready longer than one cycle");
  chk_arready_idle: assert property (s_axi_arready |-> !s_axi_rvalid)
    else $error("read address taken while data pending");
  chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == wavext_pkg::resp_slverr
    |-> s_axi_rdata == 32'h00000000) else $error("error read with nonzero data");
  chk_fault_cause: assert property (timer_error_flag |-> src_q)
    else $error("error flag without active fault input");
  chk_dir_no_rise: assert property (timer_error_flag |-> !dir_rise)
    else $error("direction restored while fault input active");
  chk_dir_restore_upd: assert property (dir_rise |-> upd_q2 || bv_q || s_axi_bvalid)
    else $error("direction restored without update");
  cover property ($rose(timer_error_flag));
  cover property (dir_rise && upd_q2);
  cover property (s_axi_rvalid && s_axi_rresp == wavext_pkg::resp_slverr);
endmodule
bind wavext_top wavext_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .event_in(event_in), .debug_break(debug_break), .update_pulse(update_pulse),
  .pin_dir(pin_dir), .timer_error_flag(timer_error_flag));

// [test/wavext_stage.sv]
`timescale 1ns/100ps
module wavext_stage (
  input  wire logic [7:0] pin_out,      // block output value
  input  wire logic [7:0] pin_override, // pins taken by the block
  input  wire logic [7:0] port_value,   // plain port register value
  input  wire logic [7:0] pin_dir,      // direction, 1 = output
  output logic      [7:0] gate          // driver inputs of the power stage
);
  // driver inputs carry pull-downs, so a tri-stated pin switches off
  assign gate = pin_dir & ((pin_override & pin_out) | (~pin_override & port_value));
endmodule
